// ==== inc/line_io_map.vh ====
// Register map, field layout and timing constants of the line I/O ports.
//
// Function
// - Each of the five pins of a channel is an input or an output as its direction bit says, in either interface mode.
// - In serial-port mode an output pin drives the level last written to the output latch and holds it until the next write.
// - In circuit-interface mode the two control/data output pins follow the first and second downstream command bits.
// - In circuit-interface mode the third to fifth output pins follow the third to fifth downstream command bits.
// - The two control/data inputs are processed only when processing is enabled, otherwise they are reported raw.
// - The first control/data input is debounced over a programmable 0 to 15 ms in 1 ms steps.
// - The second control/data input is filtered by an up/down counter sampling at a programmable interval.
// - With demultiplexing on, the first input splits in two and the second bit replaces the second control/data pin.
// - Demultiplexed bits pass through the debouncer and the counter filter like undemultiplexed inputs.
// - In serial-port mode the input read returns the third to fifth pin levels.
// - In circuit-interface mode the third pin and both processed inputs go upstream per channel.
// - In circuit-interface mode the input read returns the third to fifth pins with both control/data inputs.
`ifndef LINE_IO_MAP_VH
`define LINE_IO_MAP_VH

`define ADDR_CTRL 12'h000
`define ADDR_DIR 12'h004
`define ADDR_OUT 12'h008
`define ADDR_IN 12'h00c
`define ADDR_DEB 12'h010
`define ADDR_FILT 12'h014
`define ADDR_STAT 12'h018
`define ADDR_MASK 12'h01c

`define CTRL_MODE_BIT 0
`define CTRL_PROC_BIT 1
`define CTRL_DEMUX_BIT 2

`define CLK_HZ 25000000
`define MS_PER_S 1000
`define TICK_CYCLES (`CLK_HZ / `MS_PER_S)

`define PINS_PER_CH 5
`define FILT_LIMIT 4'h3
`define DEB_RESET 4'h0
`define FILT_RESET 4'h1

`endif

// ==== logic/line_io_ports.v ====
// Five programmable line I/O pins per channel with debounce and filtering.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "line_io_map.vh"

module line_io_ports #(
  parameter CH = 4,
  parameter TICK = `TICK_CYCLES
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Downstream command bits, five per channel, circuit-interface mode.
  input wire [5*CH-1:0] downBits,
  // Upstream indication: third pin, processed b, processed a per channel.
  output reg [3*CH-1:0] upBits,
  // Line pins, index 0 is ctrl_data_pin_a, 1 is ctrl_data_pin_b.
  input wire [5*CH-1:0] pinIn,
  output reg [5*CH-1:0] pinOut,
  output reg [5*CH-1:0] pinOe,
  // Interrupt.
  output reg irq
);

  localparam N = 5 * CH;

  reg [2:0] ctrl_reg;
  reg [N-1:0] dir_reg;
  reg [N-1:0] outLatch_reg;
  reg [4*CH-1:0] debTime_reg;
  reg [4*CH-1:0] filtTime_reg;
  reg [2*CH-1:0] stat_reg;
  reg [2*CH-1:0] mask_reg;
  reg [N-1:0] sync1_reg;
  reg [N-1:0] sync2_reg;
  reg [N-1:0] downSync1_reg;
  reg [N-1:0] downSync2_reg;
  reg [14:0] tick_reg;
  reg msTick_reg;
  reg strobe_reg;
  reg [4*CH-1:0] debCnt_reg;
  reg [CH-1:0] debOut_reg;
  reg [4*CH-1:0] intCnt_reg;
  reg [4*CH-1:0] udCnt_reg;
  reg [CH-1:0] filtOut_reg;
  reg [CH-1:0] demuxA_reg;
  reg [CH-1:0] demuxB_reg;

  wire gciMode = ctrl_reg[`CTRL_MODE_BIT];
  wire procEn = ctrl_reg[`CTRL_PROC_BIT];
  wire demuxEn = ctrl_reg[`CTRL_DEMUX_BIT];
  wire access = psel & penable;
  wire wrEn = access & pwrite;

  reg [CH-1:0] rawA;
  reg [CH-1:0] rawB;
  reg [CH-1:0] repA;
  reg [CH-1:0] repB;
  reg [N-1:0] drive;
  reg [31:0] readMux;
  reg mapped;
  integer i;

  // Millisecond time base; the demux strobe alternates each tick.
  always @(posedge clk) begin
    if (srst) begin
      tick_reg <= 15'h0000;
      msTick_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else if (tick_reg == TICK - 1) begin
      tick_reg <= 15'h0000;
      msTick_reg <= 1'b1;
      strobe_reg <= ~strobe_reg;
    end else begin
      tick_reg <= tick_reg + 15'h0001;
      msTick_reg <= 1'b0;
    end
  end

  // Two-stage synchronisers for pins and downstream bits.
  always @(posedge clk) begin
    if (srst) begin
      sync1_reg <= {N{1'b0}};
      sync2_reg <= {N{1'b0}};
      downSync1_reg <= {N{1'b0}};
      downSync2_reg <= {N{1'b0}};
    end else begin
      sync1_reg <= pinIn;
      sync2_reg <= sync1_reg;
      downSync1_reg <= downBits;
      downSync2_reg <= downSync1_reg;
    end
  end

  // Demultiplexer samples pin a in each half of the strobe cycle.
  always @(posedge clk) begin
    if (srst) begin
      demuxA_reg <= {CH{1'b0}};
      demuxB_reg <= {CH{1'b0}};
    end else if (msTick_reg) begin
      for (i = 0; i < CH; i = i + 1) begin
        if (strobe_reg)
          demuxB_reg[i] <= sync2_reg[5*i];
        else
          demuxA_reg[i] <= sync2_reg[5*i];
      end
    end
  end

  always @* begin
    for (i = 0; i < CH; i = i + 1) begin
      rawA[i] = demuxEn ? demuxA_reg[i] : sync2_reg[5*i];
      rawB[i] = demuxEn ? demuxB_reg[i] : sync2_reg[5*i+1];
      repA[i] = procEn ? debOut_reg[i] : rawA[i];
      repB[i] = procEn ? filtOut_reg[i] : rawB[i];
    end
  end

  // Debouncer on input a and up/down filter on input b.
  always @(posedge clk) begin
    if (srst) begin
      debCnt_reg <= {4*CH{1'b0}};
      debOut_reg <= {CH{1'b0}};
      intCnt_reg <= {4*CH{1'b0}};
      udCnt_reg <= {4*CH{1'b0}};
      filtOut_reg <= {CH{1'b0}};
    end else begin
      for (i = 0; i < CH; i = i + 1) begin
        if (rawA[i] == debOut_reg[i]) begin
          debCnt_reg[4*i +: 4] <= 4'h0;
        end else if (debCnt_reg[4*i +: 4] >= debTime_reg[4*i +: 4]) begin
          debOut_reg[i] <= rawA[i];
          debCnt_reg[4*i +: 4] <= 4'h0;
        end else if (msTick_reg) begin
          debCnt_reg[4*i +: 4] <= debCnt_reg[4*i +: 4] + 4'h1;
        end
        if (msTick_reg) begin
          if (intCnt_reg[4*i +: 4] >= filtTime_reg[4*i +: 4]) begin
            intCnt_reg[4*i +: 4] <= 4'h0;
            if (rawB[i] && udCnt_reg[4*i +: 4] < `FILT_LIMIT)
              udCnt_reg[4*i +: 4] <= udCnt_reg[4*i +: 4] + 4'h1;
            else if (!rawB[i] && udCnt_reg[4*i +: 4] != 4'h0)
              udCnt_reg[4*i +: 4] <= udCnt_reg[4*i +: 4] - 4'h1;
            if (rawB[i] && udCnt_reg[4*i +: 4] == `FILT_LIMIT - 4'h1)
              filtOut_reg[i] <= 1'b1;
            else if (!rawB[i] && udCnt_reg[4*i +: 4] == 4'h1)
              filtOut_reg[i] <= 1'b0;
          end else begin
            intCnt_reg[4*i +: 4] <= intCnt_reg[4*i +: 4] + 4'h1;
          end
        end
      end
    end
  end

  // Output level source depends on interface mode.
  always @* begin
    drive = gciMode ? downSync2_reg : outLatch_reg;
  end

  always @(posedge clk) begin
    if (srst) begin
      pinOut <= {N{1'b0}};
      pinOe <= {N{1'b0}};
      upBits <= {3*CH{1'b0}};
    end else begin
      pinOut <= drive & dir_reg;
      pinOe <= dir_reg;
      for (i = 0; i < CH; i = i + 1) begin
        upBits[3*i] <= repA[i];
        upBits[3*i+1] <= repB[i];
        upBits[3*i+2] <= sync2_reg[5*i+2];
      end
    end
  end

  // Read data: in serial mode only pins three to five, else all five.
  always @* begin
    readMux = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `ADDR_CTRL: readMux[2:0] = ctrl_reg;
      `ADDR_DIR: readMux[N-1:0] = dir_reg;
      `ADDR_OUT: readMux[N-1:0] = outLatch_reg;
      `ADDR_IN: begin
        for (i = 0; i < CH; i = i + 1) begin
          readMux[5*i+2] = sync2_reg[5*i+2];
          readMux[5*i+3] = sync2_reg[5*i+3];
          readMux[5*i+4] = sync2_reg[5*i+4];
          readMux[5*i] = gciMode & repA[i];
          readMux[5*i+1] = gciMode & repB[i];
        end
      end
      `ADDR_DEB: readMux[4*CH-1:0] = debTime_reg;
      `ADDR_FILT: readMux[4*CH-1:0] = filtTime_reg;
      `ADDR_STAT: readMux[2*CH-1:0] = stat_reg;
      `ADDR_MASK: readMux[2*CH-1:0] = mask_reg;
      default: mapped = 1'b0;
    endcase
  end

  // APB slave with one wait state; events set status, set beats clear.
  always @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= 3'h0;
      dir_reg <= {N{1'b0}};
      outLatch_reg <= {N{1'b0}};
      debTime_reg <= {CH{`DEB_RESET}};
      filtTime_reg <= {CH{`FILT_RESET}};
      stat_reg <= {2*CH{1'b0}};
      mask_reg <= {2*CH{1'b0}};
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready & ~pwrite)
        prdata <= readMux;
      if (wrEn & pready) begin
        case (paddr)
          `ADDR_CTRL: ctrl_reg <= pwdata[2:0];
          `ADDR_DIR: dir_reg <= pwdata[N-1:0];
          `ADDR_OUT: outLatch_reg <= pwdata[N-1:0];
          `ADDR_DEB: debTime_reg <= pwdata[4*CH-1:0];
          `ADDR_FILT: filtTime_reg <= pwdata[4*CH-1:0];
          `ADDR_MASK: mask_reg <= pwdata[2*CH-1:0];
          default: ;
        endcase
      end
      for (i = 0; i < CH; i = i + 1) begin
        if (upBits[3*i] != repA[i])
          stat_reg[2*i] <= 1'b1;
        else if (wrEn & pready & (paddr == `ADDR_STAT) & pwdata[2*i])
          stat_reg[2*i] <= 1'b0;
        if (upBits[3*i+1] != repB[i])
          stat_reg[2*i+1] <= 1'b1;
        else if (wrEn & pready & (paddr == `ADDR_STAT) & pwdata[2*i+1])
          stat_reg[2*i+1] <= 1'b0;
      end
      irq <= |(stat_reg & mask_reg);
    end
  end

endmodule

// ==== test/line_io_ports_assertions.sv ====
// Concurrent checks on the line I/O port block pins.
`timescale 1ns/100ps
module line_io_ports_checker #(parameter CH = 4) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // APB.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line side and interrupt.
  input wire [3*CH-1:0] upBits,
  input wire [5*CH-1:0] pinOut,
  input wire [5*CH-1:0] pinOe,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  reg [5*CH-1:0] dirVal;
  wire dirWr = pready && psel && pwrite && paddr == 12'h004;
  wire mskOff = pready && pwrite && paddr == 12'h01c && pwdata == 32'h0;
  always @(posedge clk) begin
    if (dirWr) begin
      dirVal <= pwdata[5*CH-1:0];
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; s_setup ##1 psel && penable; endsequence
  property p_ready; s_acc |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_slv; pslverr |-> pready; endproperty
  property p_err;
    pready && paddr > 12'h01c |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_rst;
    $fell(srst) |-> pinOe == 0 && !pready && !irq && upBits == 0;
  endproperty
  property p_oe; (pinOut & ~pinOe) == 0; endproperty
  property p_dir; dirWr |-> ##2 pinOe == dirVal; endproperty
  property p_hold; $changed(pinOe) |-> $past(dirWr, 2) || $past(srst); endproperty
  property p_irq; mskOff |-> ##2 !irq; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_slv: assert property (p_slv) else $error("error without ready");
  a_err: assert property (p_err) else $error("unmapped not refused");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_oe: assert property (p_oe) else $error("input pin driven");
  a_dir: assert property (p_dir) else $error("direction wrong");
  a_hold: assert property (p_hold) else $error("direction moved");
  a_irq: assert property (p_irq) else $error("masked irq high");
endmodule
bind line_io_ports line_io_ports_checker #(.CH(CH)) u_chk (.clk(clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .upBits(upBits), .pinOut(pinOut), .pinOe(pinOe),
  .irq(irq));

// ==== test/line_circuit_model.sv ====
// Line interface circuit model seen through the programmable pins.
`timescale 1ns/100ps
module line_circuit_model #(parameter W = 20) (
  // Block side.
  input wire [W-1:0] pinOut,
  input wire [W-1:0] pinOe,
  output wire [W-1:0] pinIn,
  // Levels the circuit presents.
  input wire [W-1:0] lineLvl
);
  // A pin the block drives reads back its own level.
  assign pinIn = (pinOe & pinOut) | (~pinOe & lineLvl);
endmodule

// ==== test/line_io_ports_tb_top.sv ====
// Self-checking bench for the line I/O port block.
`timescale 1ns/100ps
module line_io_ports_tb_top;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0, upBits;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err;
  logic [19:0] downBits = 20'h0, lineLvl = 20'h0, pinIn, pinOut, pinOe;
  integer n_errors = 0, checks = 0;
  line_io_ports #(.CH(4), .TICK(20)) DUT (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .downBits(downBits), .upBits(upBits), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));
  line_circuit_model #(.W(20)) MODEL (.pinOut(pinOut), .pinOe(pinOe),
    .pinIn(pinIn), .lineLvl(lineLvl));
  initial forever #20 clk = ~clk;
  task finish_test;
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
        n_errors++;
        finish_test;
      end
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task t_reset;
    chk(pinOe, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h010, 32'h0);
    rdc(12'h014, 32'h1111);
    xfer(1'b0, 12'h020, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
  endtask
  task t_serial;
    wr(12'h004, 32'hfffff);
    wr(12'h008, 32'h5a5c3);
    cyc(2);
    chk(pinOut, 32'h5a5c3);
    wr(12'h004, 32'h0f0f0);
    cyc(2);
    chk(pinOe, 32'h0f0f0);
    chk(pinOut, 32'h0a0c0);
    wr(12'h004, 32'hfffff);
    cyc(2);
    chk(pinOut, 32'h5a5c3);
    wr(12'h004, 32'h0);
    lineLvl <= 20'h6b5d7;
    cyc(6);
    rdc(12'h00c, 32'h63194);
  endtask
  task t_circuit;
    wr(12'h000, 32'h1);
    wr(12'h004, 32'hfffff);
    downBits <= 20'h3a6c9;
    cyc(6);
    chk(pinOut, 32'h3a6c9);
    wr(12'h004, 32'h0);
    cyc(6);
    rdc(12'h00c, 32'h6b5d7);
    chk(upBits, 32'hb77);
  endtask
  task t_process;
    lineLvl <= 20'h0;
    wr(12'h010, 32'h3);
    wr(12'h000, 32'h3);
    cyc(200);
    wr(12'h018, 32'hff);
    wr(12'h01c, 32'h1);
    lineLvl <= 20'h3;
    cyc(25);
    chk(upBits[1:0], 32'h0);
    cyc(175);
    chk(upBits[1:0], 32'h3);
    chk(irq, 32'h1);
    wr(12'h01c, 32'h0);
    cyc(2);
    chk(irq, 32'h0);
    rdc(12'h018, 32'h3);
    wr(12'h018, 32'h3);
    rdc(12'h018, 32'h0);
  endtask
  task t_demux;
    wr(12'h000, 32'h5);
    lineLvl <= 20'h1;
    cyc(100);
    rdc(12'h00c, 32'h3);
  endtask
  initial begin
    cyc(4);
    srst <= 1'b0;
    t_reset;
    t_serial;
    t_circuit;
    t_process;
    t_demux;
    finish_test;
  end
endmodule
